/* hw/edm_map.vh */
// Register map, field positions and reset values of the encoder direction and latch monitor
`ifndef EDM_MAP_VH
`define EDM_MAP_VH

// Byte offsets on the AHB-Lite register window
`define EDM_OFS_CTRL 8'h00
`define EDM_OFS_HYST 8'h04
`define EDM_OFS_CMD 8'h08
`define EDM_OFS_STAT 8'h0C
`define EDM_OFS_LAT1 8'h10
`define EDM_OFS_LAT2 8'h14
`define EDM_OFS_POS 8'h18

// Control register fields
`define EDM_CTRL_REV 0
`define EDM_CTRL_CONT1 1
`define EDM_CTRL_CONT2 2
`define EDM_CTRL_W 3
`define EDM_CTRL_RST 3'h0

// Hysteresis register, in encoder increments; zero selects direction mode
`define EDM_HYST_W 16
`define EDM_HYST_RST 16'h0000

// Latch command register fields
`define EDM_CMD_C 0
`define EDM_CMD_XP 1
`define EDM_CMD_XN 2
`define EDM_CMD_X2P 3
`define EDM_CMD_X2N 4
`define EDM_CMD_W 5
`define EDM_CMD_RST 5'h00

// Status register fields (read only)
`define EDM_ST_CVAL 0
`define EDM_ST_XVAL 1
`define EDM_ST_X2VAL 2
`define EDM_ST_DIR 3
`define EDM_ST_LPIN 4
`define EDM_ST_GPIN 5

// Owner codes of the shared latch value
`define EDM_OWN_NONE 2'h0
`define EDM_OWN_C 2'h1
`define EDM_OWN_X 2'h2

`define EDM_CNT_W 32

`endif

/* hw/edm_top.v */
// Encoder direction / reversal detection and latch capture arbitration with an AHB-Lite slave
`timescale 1ns/1ps
`include "edm_map.vh"

module edm_top (
  input wire hclk, // 100 MHz clock
  input wire hresetn, // Asynchronous reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire hsel, // AHB-Lite slave select
  input wire [31:0] haddr, // AHB-Lite address
  input wire [1:0] htrans, // AHB-Lite transfer type
  input wire hwrite, // AHB-Lite write
  input wire [2:0] hsize, // AHB-Lite size, word only
  input wire [31:0] hwdata, // AHB-Lite write data
  input wire hready, // AHB-Lite bus ready
  output reg [31:0] hrdata, // AHB-Lite read data
  output reg hreadyout, // AHB-Lite slave ready
  output reg hresp, // AHB-Lite response, always OKAY
  input wire cyc_stb, // Control-cycle strobe, one hclk pulse
  input wire [31:0] cnt_val, // Current encoder counter value
  input wire cnt_step, // Counter moved by one increment
  input wire cnt_step_dn, // Direction of that increment, 1 = down
  input wire cnt_ovf, // Counter wrapped upward
  input wire cnt_unf, // Counter wrapped downward
  input wire trk_c, // Zero pulse track pin
  input wire lat_pin, // Latch input pin
  input wire gate_pin, // Gate/latch input pin
  output reg dir_flag, // Direction / inversion flag
  output reg [31:0] lat1_val, // Shared latch value
  output reg [31:0] lat2_val, // Second latch value
  output reg lat_c_vld, // Zero pulse capture valid
  output reg lat_x_vld, // Latch input capture valid
  output reg lat_x2_vld // Gate/latch input capture valid
);

  // ==========================================================
  // Shared helper functions
  // Edge tests on a pair of consecutive samples, used for pins and command bits
  function rose_of;
    input now;
    input old;
    begin
      rose_of = now & ~old;
    end
  endfunction

  function fell_of;
    input now;
    input old;
    begin
      fell_of = ~now & old;
    end
  endfunction

  // Capture event of one latch input under its two edge enables
  function edge_hit;
    input rise;
    input fall;
    input en_rise;
    input en_fall;
    begin
      edge_hit = (rise & en_rise) | (fall & en_fall);
    end
  endfunction

  // Once mode takes only the first event after arming; continuous mode takes all
  function cap_ok;
    input ev;
    input done;
    input cont;
    begin
      cap_ok = ev & (~done | cont);
    end
  endfunction

  // ==========================================================
  // Pin synchronisers and edge detection
  reg [2:0] sy1_q;
  reg [2:0] sy2_q;
  reg [2:0] sy3_q;
  wire c_rise;
  wire x_rise;
  wire x_fall;
  wire x2_rise;
  wire x2_fall;

  // Only the second and third stages feed the edge detectors; first stage is metastability guard
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
      sy3_q <= 3'h0;
    end else if (ce) begin
      sy1_q <= {gate_pin, lat_pin, trk_c};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  assign c_rise = rose_of(sy2_q[0], sy3_q[0]);
  assign x_rise = rose_of(sy2_q[1], sy3_q[1]);
  assign x_fall = fell_of(sy2_q[1], sy3_q[1]);
  assign x2_rise = rose_of(sy2_q[2], sy3_q[2]);
  assign x2_fall = fell_of(sy2_q[2], sy3_q[2]);

  // ==========================================================
  // AHB-Lite slave
  reg [`EDM_CTRL_W-1:0] ctrl_q;
  reg [`EDM_HYST_W-1:0] hyst_q;
  reg [`EDM_CMD_W-1:0] cmd_q;
  reg [31:0] pos_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [31:0] rd_d;
  wire bus_go;

  assign bus_go = hsel & htrans[1] & hready;

  // Unmapped offsets read as zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `EDM_OFS_CTRL: rd_d = {29'h0000_0000, ctrl_q};
      `EDM_OFS_HYST: rd_d = {16'h0000, hyst_q};
      `EDM_OFS_CMD: rd_d = {27'h0000_0000, cmd_q};
      `EDM_OFS_STAT: rd_d = {26'h0000_0000, sy3_q[2], sy3_q[1], dir_flag,
                             lat_x2_vld, lat_x_vld, lat_c_vld};
      `EDM_OFS_LAT1: rd_d = lat1_val;
      `EDM_OFS_LAT2: rd_d = lat2_val;
      `EDM_OFS_POS: rd_d = pos_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Zero wait states: read data is fetched in the address phase so the
  // output stays a plain flip-flop during the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl_q <= `EDM_CTRL_RST;
      hyst_q <= `EDM_HYST_RST;
      cmd_q <= `EDM_CMD_RST;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= bus_go & hwrite;
      if (bus_go) begin
        wr_addr_q <= haddr[7:0];
      end
      if (bus_go & ~hwrite) begin
        hrdata <= rd_d;
      end
      // Writes land in the data phase, when hwdata stands
      if (wr_pend_q) begin
        case (wr_addr_q)
          `EDM_OFS_CTRL: ctrl_q <= hwdata[`EDM_CTRL_W-1:0];
          `EDM_OFS_HYST: hyst_q <= hwdata[`EDM_HYST_W-1:0];
          `EDM_OFS_CMD: cmd_q <= hwdata[`EDM_CMD_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Direction mode and reversal detection
  reg started_q;
  reg wrap_q;
  reg run_dn_q;
  reg set_dn_q;
  reg set_ok_q;
  reg hit_q;
  reg [`EDM_HYST_W:0] run_q;
  wire [31:0] diff;
  wire rev;
  wire step_dn;
  wire rev_mode;
  wire [`EDM_HYST_W:0] run_nx;
  wire [`EDM_HYST_W:0] hyst_x;
  wire step_hit;

  assign rev = ctrl_q[`EDM_CTRL_REV];
  assign rev_mode = (hyst_q != `EDM_HYST_RST);
  assign diff = cnt_val - pos_q;
  assign step_dn = cnt_step_dn ^ rev;
  assign hyst_x = {1'b0, hyst_q};

  // Saturating run length: a new direction restarts at one edge
  function [`EDM_HYST_W:0] run_next;
    input [`EDM_HYST_W:0] cur;
    input same;
    begin
      if (!same) begin
        run_next = {{`EDM_HYST_W{1'b0}}, 1'b1};
      end else if (&cur) begin
        run_next = cur;
      end else begin
        run_next = cur + {{`EDM_HYST_W{1'b0}}, 1'b1};
      end
    end
  endfunction

  assign run_nx = run_next(run_q, (step_dn == run_dn_q) && (|run_q));
  // An inversion on the strobe edge itself belongs to the cycle being closed
  assign step_hit = cnt_step && (run_nx > hyst_x) && set_ok_q && (step_dn != set_dn_q);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      started_q <= 1'b0;
      wrap_q <= 1'b0;
      pos_q <= 32'h0000_0000;
      dir_flag <= 1'b0;
      run_q <= {(`EDM_HYST_W+1){1'b0}};
      run_dn_q <= 1'b0;
      set_dn_q <= 1'b0;
      set_ok_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (ce) begin
      // Any wrap since the last sample makes this cycle's difference unusable
      if (cnt_ovf | cnt_unf) begin
        wrap_q <= 1'b1;
      end
      if (cnt_step) begin
        run_q <= run_nx;
        run_dn_q <= step_dn;
        // Jitter that turns back before passing the window never gets here
        if ((run_nx > hyst_x) && (!set_ok_q || (step_dn != set_dn_q))) begin
          set_ok_q <= 1'b1;
          set_dn_q <= step_dn;
          // The first settled direction is no inversion
          if (set_ok_q) begin
            hit_q <= 1'b1;
          end
        end
      end
      if (cyc_stb) begin
        started_q <= 1'b1;
        pos_q <= cnt_val;
        wrap_q <= 1'b0;
        hit_q <= 1'b0;
        run_q <= {(`EDM_HYST_W+1){1'b0}};
        if (rev_mode) begin
          // One cycle pulse, re-set by any inversion in the cycle just ended
          dir_flag <= hit_q | step_hit;
        end else if (!started_q) begin
          dir_flag <= 1'b0;
        end else if ((diff != 32'h0000_0000) && !wrap_q && !cnt_ovf && !cnt_unf) begin
          // A load to a lower value shows as a negative difference
          dir_flag <= diff[31] ^ rev;
        end
      end
    end
  end

  // ==========================================================
  // Shared latch value with first-command arbitration
  reg [1:0] own_q;
  reg done1_q;
  reg [`EDM_CMD_W-1:0] cmd_old_q;
  wire any1;
  wire x_ev;
  wire c_new;
  wire x_new;
  wire x_cont;

  assign any1 = cmd_q[`EDM_CMD_C] | cmd_q[`EDM_CMD_XP] | cmd_q[`EDM_CMD_XN];
  assign x_ev = edge_hit(x_rise, x_fall, cmd_q[`EDM_CMD_XP], cmd_q[`EDM_CMD_XN]);
  assign c_new = rose_of(cmd_q[`EDM_CMD_C], cmd_old_q[`EDM_CMD_C]);
  assign x_new = rose_of(cmd_q[`EDM_CMD_XP], cmd_old_q[`EDM_CMD_XP]) |
                 rose_of(cmd_q[`EDM_CMD_XN], cmd_old_q[`EDM_CMD_XN]);
  // Continuous mode only while the zero-pulse command is not also active
  assign x_cont = ctrl_q[`EDM_CTRL_CONT1] & ~cmd_q[`EDM_CMD_C];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      own_q <= `EDM_OWN_NONE;
      done1_q <= 1'b0;
      cmd_old_q <= `EDM_CMD_RST;
      lat1_val <= 32'h0000_0000;
      lat_c_vld <= 1'b0;
      lat_x_vld <= 1'b0;
    end else if (ce) begin
      // Previous command word, to tell which command was set first
      cmd_old_q <= cmd_q;
      if (!any1) begin
        // Nothing active: release the owner and clear confirmations
        own_q <= `EDM_OWN_NONE;
        done1_q <= 1'b0;
        lat_c_vld <= 1'b0;
        lat_x_vld <= 1'b0;
      end else begin
        case (own_q)
          `EDM_OWN_NONE: begin
            if (!done1_q) begin
              if (c_new) begin
                own_q <= `EDM_OWN_C;
              end else if (x_new) begin
                own_q <= `EDM_OWN_X;
              end
            end
          end
          `EDM_OWN_C: begin
            if (c_rise && !done1_q) begin
              lat1_val <= cnt_val;
              lat_c_vld <= 1'b1;
              done1_q <= 1'b1;
            end
          end
          `EDM_OWN_X: begin
            if (cap_ok(x_ev, done1_q, x_cont)) begin
              lat1_val <= cnt_val;
              lat_x_vld <= 1'b1;
              done1_q <= 1'b1;
            end
          end
          // Unused owner code falls back to no owner
          default: own_q <= `EDM_OWN_NONE;
        endcase
      end
    end
  end

  // ==========================================================
  // Second latch on the gate/latch input
  reg done2_q;
  wire any2;
  wire x2_ev;

  assign any2 = cmd_q[`EDM_CMD_X2P] | cmd_q[`EDM_CMD_X2N];
  assign x2_ev = edge_hit(x2_rise, x2_fall, cmd_q[`EDM_CMD_X2P], cmd_q[`EDM_CMD_X2N]);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done2_q <= 1'b0;
      lat2_val <= 32'h0000_0000;
      lat_x2_vld <= 1'b0;
    end else if (ce) begin
      // Releasing both edge commands is the only way to re-arm once mode
      if (!any2) begin
        done2_q <= 1'b0;
        lat_x2_vld <= 1'b0;
      end else if (cap_ok(x2_ev, done2_q, ctrl_q[`EDM_CTRL_CONT2])) begin
        lat2_val <= cnt_val;
        lat_x2_vld <= 1'b1;
        done2_q <= 1'b1;
      end
    end
  end

endmodule

/* dv/edm_enc_model.sv */
// Behavioural encoder counter and latch pin source
`timescale 1ns/1ps
module edm_enc_model (
  input wire hclk, // Clock
  output logic [31:0] cnt_val, // Counter
  output logic cnt_step, // Step pulse
  output logic cnt_step_dn, // Step down
  output logic cnt_ovf, // Wrap up
  output logic cnt_unf, // Wrap down
  output logic trk_c, // Zero pulse
  output logic lat_pin, // Latch pin
  output logic gate_pin // Gate pin
);
  // ==========================================
  // Stimulus tasks
  initial {cnt_val, cnt_step, cnt_step_dn, cnt_ovf, cnt_unf, trk_c, lat_pin, gate_pin} = '0;
  // Two clocks per increment, wrap flag on roll-over
  task automatic mv(input logic dn, input int n);
    repeat (n) begin
      @(posedge hclk);
      cnt_step <= 1'b1;
      cnt_step_dn <= dn;
      cnt_ovf <= !dn && cnt_val == 32'hFFFFFFFF;
      cnt_unf <= dn && cnt_val == 32'h0;
      cnt_val <= dn ? cnt_val - 32'h1 : cnt_val + 32'h1;
      @(posedge hclk);
      {cnt_step, cnt_ovf, cnt_unf} <= 3'h0;
    end
  endtask
  // Preset jump with no steps
  task automatic ld(input logic [31:0] v);
    @(posedge hclk);
    cnt_val <= v;
  endtask
  task automatic drv(input int k, input logic v);
    case (k)
      0: trk_c <= v;
      1: lat_pin <= v;
      default: gate_pin <= v;
    endcase
  endtask
  // Held six clocks so the two-flop synchroniser cannot miss it
  task automatic pulse(input int k);
    @(posedge hclk);
    drv(k, 1'b1);
    repeat (6) @(posedge hclk);
    drv(k, 1'b0);
    repeat (6) @(posedge hclk);
    #1;
  endtask
endmodule

/* dv/edm_top_assertions.sv */
// Port checker of the encoder direction and latch monitor
`timescale 1ns/1ps
`include "edm_map.vh"
module edm_top_assertions (
  input wire hclk, // Clock
  input wire hresetn, // Reset
  input wire hsel, // Select
  input wire [31:0] haddr, // Address
  input wire [1:0] htrans, // Transfer
  input wire hwrite, // Write
  input wire hready, // Ready
  input wire [31:0] hwdata, // Write data
  input wire cyc_stb, // Strobe
  input wire [31:0] cnt_val, // Counter
  input wire dir_flag, // Flag
  input wire [31:0] lat1_val, // Latch 1
  input wire [31:0] lat2_val, // Latch 2
  input wire lat_c_vld, // C valid
  input wire lat_x_vld, // X valid
  input wire lat_x2_vld // X2 valid
);
  // ==========================================
  // Properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cmd_addr;
    hsel && htrans[1] && hready && hwrite && haddr[7:0] == `EDM_OFS_CMD;
  endsequence
  sequence s_cmd_clear;
    s_cmd_addr ##1 hwdata[2:0] == 3'h0;
  endsequence
  a_cmd_clear: assert property (s_cmd_clear |-> ##[1:3] !lat_c_vld && !lat_x_vld)
    else $error("latch valid kept");
  a_flag_on_stb: assert property ($changed(dir_flag) |-> $past(cyc_stb))
    else $error("flag moved off strobe");
  a_one_owner: assert property (!(lat_c_vld && lat_x_vld))
    else $error("two owners");
  a_lat1_src: assert property ($changed(lat1_val) |-> lat_c_vld || lat_x_vld)
    else $error("latch 1 moved");
  a_lat2_src: assert property ($changed(lat2_val) |-> lat_x2_vld)
    else $error("latch 2 moved");
  a_cap_c: assert property ($rose(lat_c_vld) |-> lat1_val == $past(cnt_val))
    else $error("c capture value");
  a_cap_x: assert property ($rose(lat_x_vld) |-> lat1_val == $past(cnt_val))
    else $error("x capture value");
  a_cap_x2: assert property ($rose(lat_x2_vld) |-> lat2_val == $past(cnt_val))
    else $error("x2 capture value");
endmodule
bind edm_top edm_top_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .cyc_stb, .cnt_val, .dir_flag, .lat1_val, .lat2_val, .lat_c_vld,
  .lat_x_vld, .lat_x2_vld);

/* dv/edm_top_test.sv */
// Self-checking bench of the encoder direction and latch monitor
`timescale 1ns/1ps
`include "edm_map.vh"
module edm_top_test;
  logic hclk, hresetn, ce, hsel, hwrite, cyc_stb;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata, cnt_val, lat1_val, lat2_val;
  wire hreadyout, hresp, cnt_step, cnt_step_dn, cnt_ovf, cnt_unf, trk_c, lat_pin, gate_pin;
  wire dir_flag, lat_c_vld, lat_x_vld, lat_x2_vld;
  int fail_count = 0, check_count = 0, cyc_n = 0;
  // ==========================================
  // Design, model and helpers
  always #5 hclk = ~hclk;
  edm_top DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cyc_stb, .cnt_val, .cnt_step,
    .cnt_step_dn, .cnt_ovf, .cnt_unf, .trk_c, .lat_pin, .gate_pin, .dir_flag, .lat1_val,
    .lat2_val, .lat_c_vld, .lat_x_vld, .lat_x2_vld);
  edm_enc_model m (.hclk, .cnt_val, .cnt_step, .cnt_step_dn, .cnt_ovf, .cnt_unf, .trk_c,
    .lat_pin, .gate_pin);
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ck1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task bus(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [31:0] a, v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask
  task rc(input logic [31:0] a, exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask
  task stb_raw;
    @(posedge hclk);
    cyc_stb <= 1'b1;
    @(posedge hclk);
    cyc_stb <= 1'b0;
    #1;
  endtask
  task stb(input logic exp);
    stb_raw;
    ck1(dir_flag, exp);
  endtask
  task sk;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    rc(`EDM_OFS_HYST, 32'h0);
    wr(32'h1C, 32'hFFFF);
    rc(32'h1C, 32'h0);
    wr(`EDM_OFS_CTRL, 32'h6);
    rc(`EDM_OFS_CTRL, 32'h6);
    wr(`EDM_OFS_CTRL, 32'h0);
  endtask
  task t_dir;
    m.mv(1'b0, 3);
    stb(1'b0);
    m.mv(1'b0, 2);
    stb(1'b0);
    m.mv(1'b1, 1);
    stb(1'b1);
    stb(1'b1);
    m.mv(1'b0, 1);
    stb(1'b0);
    m.ld(32'h1);
    m.mv(1'b1, 2);
    stb(1'b0);
    m.mv(1'b1, 1);
    stb(1'b1);
    m.mv(1'b0, 1);
    stb(1'b0);
    m.ld(32'hFFFFFF00);
    stb(1'b1);
    wr(`EDM_OFS_CTRL, 32'h1);
    m.mv(1'b0, 2);
    stb(1'b1);
    wr(`EDM_OFS_CTRL, 32'h0);
  endtask
  task t_rev;
    wr(`EDM_OFS_HYST, 32'h2);
    m.mv(1'b0, 3);
    stb_raw;
    m.mv(1'b0, 3);
    stb(1'b0);
    m.mv(1'b1, 1);
    m.mv(1'b0, 1);
    stb(1'b0);
    m.mv(1'b1, 3);
    stb(1'b1);
    stb(1'b0);
    m.mv(1'b0, 3);
    m.mv(1'b1, 3);
    stb(1'b1);
    m.mv(1'b0, 3);
    stb(1'b1);
    m.mv(1'b1, 2);
    stb(1'b0);
    m.mv(1'b1, 2);
    stb(1'b0);
    wr(`EDM_OFS_HYST, 32'h1);
    m.mv(1'b1, 2);
    stb(1'b1);
    wr(`EDM_OFS_HYST, 32'h0);
  endtask
  task t_latch;
    wr(`EDM_OFS_CMD, 32'h3);
    m.ld(32'h55);
    m.pulse(1);
    ck1(lat_x_vld, 1'b0);
    m.pulse(0);
    chk(lat1_val, 32'h55);
    ck1(lat_c_vld, 1'b1);
    m.ld(32'h66);
    m.pulse(0);
    chk(lat1_val, 32'h55);
    wr(`EDM_OFS_CMD, 32'h2);
    sk;
    ck1(lat_c_vld, 1'b1);
    wr(`EDM_OFS_CMD, 32'h0);
    sk;
    ck1(lat_c_vld, 1'b0);
    wr(`EDM_OFS_CMD, 32'h2);
    m.pulse(1);
    chk(lat1_val, 32'h66);
    m.ld(32'h77);
    m.pulse(1);
    chk(lat1_val, 32'h66);
    wr(`EDM_OFS_CTRL, 32'h4);
    wr(`EDM_OFS_CMD, 32'h8);
    m.pulse(2);
    chk(lat2_val, 32'h77);
    m.ld(32'h88);
    m.pulse(2);
    chk(lat2_val, 32'h88);
    ck1(lat_x2_vld, 1'b1);
    wr(`EDM_OFS_CMD, 32'h14);
    m.ld(32'h99);
    m.pulse(1);
    chk(lat1_val, 32'h99);
    m.pulse(2);
    chk(lat2_val, 32'h99);
    rc(`EDM_OFS_STAT, 32'h6);
  endtask
  task t_ce;
    @(posedge hclk);
    ce <= 1'b0;
    m.mv(1'b0, 2);
    stb(1'b1);
    @(posedge hclk);
    ce <= 1'b1;
    stb(1'b0);
    rc(`EDM_OFS_POS, 32'hFFFFFF04);
  endtask
  task t_rst;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk(lat1_val | lat2_val, 32'h0);
    chk({26'h0, hreadyout, hresp, dir_flag, lat_c_vld, lat_x_vld, lat_x2_vld}, 32'h20);
    @(posedge hclk);
    hresetn <= 1'b1;
    rc(`EDM_OFS_CMD, 32'h0);
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    {hsel, hwrite, cyc_stb} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_dir;
    t_rev;
    t_ce;
    t_latch;
    t_rst;
    end_sim;
  end
  // Hang guard, far above the few hundred clocks the run needs
  always @(posedge hclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      end_sim;
    end
  end
endmodule
